/* shared/prog_entry_cfg.svh */
`ifndef PROG_ENTRY_CFG_SVH
`define PROG_ENTRY_CFG_SVH

// system clock period in ns (100 MHz)
`define CLK_PERIOD_NS        10
// window for initial communication settings after the resets end
`define INIT_WINDOW_MS       100
`define INIT_WINDOW_CYC      ((`INIT_WINDOW_MS * 1000000) / `CLK_PERIOD_NS)
// least low hold of the mode pin after the resets end, in ns
`define HOLD_LOW_NS          1000
`define HOLD_LOW_CYC         ((`HOLD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// bit times at 100 MHz for 115200, 250000, 500000 and 1000000 bps
`define BIT_CYC_115K         16'h0364
`define BIT_CYC_250K         16'h0190
`define BIT_CYC_500K         16'h00c8
`define BIT_CYC_1M           16'h0064
// baud code carried in the setting byte
`define BAUD_CODE_115K       2'h0
`define BAUD_CODE_250K       2'h1
`define BAUD_CODE_500K       2'h2
`define BAUD_CODE_1M         2'h3
// the setting byte is marked by this upper nibble
`define BAUD_SET_MARK        4'ha
// option byte flash operation mode encodings
`define FOM_LV               2'h0
`define FOM_LS               2'h1
`define FOM_HS               2'h3
`define FOM_BLANK            2'h2

`endif

/* shared/prog_entry_pkg.sv */
package prog_entry_pkg;

    // overall entry sequence
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_HOLD_LOW,
        ST_WAIT_HIGH,
        ST_WAIT_BAUD,
        ST_READY,
        ST_TIMEOUT
    } entry_state_e;

    // receiver state
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_e;

endpackage : prog_entry_pkg

/* logic/flash_program_mode_entry.sv */
`timescale 1ns/100ps
`include "prog_entry_cfg.svh"

// Functional notes
// [RULE1] mode pin low at release enters programming
// [RULE2] host drives pin low before reset ends
// [RULE3] host holds pin low minimum interval
// [RULE4] entry completes after baud rate setting
// [RULE5] host finishes settings within 100 ms
// [RULE6] programmer communication enters mode automatically
// [RULE7] option byte selects full speed or wide
// [RULE8] blank option byte uses supply range
// [RULE9] both modes allow write, erase, verify
// [RULE10] one-wire or two-wire UART, four rates
// [RULE11] host evaluates slew and baud error
// [RULE12] host tx to rx, port drives pin
// [RULE13] pin sampled only at reset release
module flash_program_mode_entry #(
    parameter int unsigned INIT_WINDOW_CYC = `INIT_WINDOW_CYC,
    parameter int unsigned HOLD_LOW_CYC    = `HOLD_LOW_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       internal_resets_done_i,
    input  wire logic       mode_serial_pin_i,
    output logic            mode_serial_pin_o,
    output logic            mode_serial_pin_oe_o,
    input  wire logic       prog_uart_rx_pin_i,
    output logic            prog_uart_tx_pin_o,
    input  wire logic       two_wire_sel_i,
    input  wire logic [1:0] flash_op_mode_i,
    input  wire logic       supply_low_range_i,
    input  wire logic       tx_start_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_busy_o,
    output logic            prog_mode_o,
    output logic            entry_done_o,
    output logic            entry_timeout_o,
    output logic            full_speed_o,
    output logic            write_erase_verify_en_o,
    output logic [1:0]      baud_code_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);

    if (HOLD_LOW_CYC < 1 || INIT_WINDOW_CYC <= HOLD_LOW_CYC) begin : g_chk
        $error("timing parameters out of range");
    end

    // ------------------------------------------------------------
    // mode capture at reset release
    // ------------------------------------------------------------
    logic                          rel_seen_q;
    logic                          prog_q;
    logic                          full_speed_q;
    prog_entry_pkg::entry_state_e  st_q;
    logic [31:0]                   cnt_q;
    logic [1:0]                    baud_q;
    logic                          ser_rx;
    logic                          rx_valid_q;
    logic [7:0]                    rx_data_q;

    function automatic logic [15:0] bit_cyc(input logic [1:0] code);
        case (code)
            `BAUD_CODE_115K: bit_cyc = `BIT_CYC_115K;
            `BAUD_CODE_250K: bit_cyc = `BIT_CYC_250K;
            `BAUD_CODE_500K: bit_cyc = `BIT_CYC_500K;
            default:         bit_cyc = `BIT_CYC_1M;
        endcase
    endfunction : bit_cyc

    // sampled once, first edge after release; later pin moves ignored
    // [RULE1] [RULE13] single sample
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rel_seen_q <= 1'b0;
            prog_q     <= 1'b0;
        end else if (!rel_seen_q) begin
            rel_seen_q <= 1'b1;
            prog_q     <= ~mode_serial_pin_i;
        end
    end

    // option byte mapping, latched with the mode
    // [RULE7] [RULE8] mode select
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            full_speed_q <= 1'b0;
        end else if (!rel_seen_q) begin
            case (flash_op_mode_i)
                `FOM_HS:    full_speed_q <= 1'b1;
                `FOM_BLANK: full_speed_q <= ~supply_low_range_i;
                default:    full_speed_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // entry sequence
    // ------------------------------------------------------------
    // hold counts only once internal resets are also over; host owns
    // the low hold and the 100 ms budget, we only flag a miss
    // [RULE3] [RULE4] [RULE5] [RULE6] entry handshake
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q   <= prog_entry_pkg::ST_NORMAL;
            cnt_q  <= 32'h0000_0000;
            baud_q <= `BAUD_CODE_115K;
        end else begin
            if (st_q != prog_entry_pkg::ST_NORMAL && internal_resets_done_i
                && cnt_q < INIT_WINDOW_CYC)
                cnt_q <= cnt_q + 32'h0000_0001;
            case (st_q)
                prog_entry_pkg::ST_NORMAL: begin
                    if (!rel_seen_q && !mode_serial_pin_i)
                        st_q <= prog_entry_pkg::ST_HOLD_LOW;
                end
                prog_entry_pkg::ST_HOLD_LOW: begin
                    if (cnt_q >= HOLD_LOW_CYC)
                        st_q <= prog_entry_pkg::ST_WAIT_HIGH;
                end
                prog_entry_pkg::ST_WAIT_HIGH: begin
                    if (mode_serial_pin_i)
                        st_q <= prog_entry_pkg::ST_WAIT_BAUD;
                    else if (cnt_q >= INIT_WINDOW_CYC)
                        st_q <= prog_entry_pkg::ST_TIMEOUT;
                end
                prog_entry_pkg::ST_WAIT_BAUD: begin
                    if (rx_valid_q &&
                        rx_data_q[7:4] == `BAUD_SET_MARK) begin
                        baud_q <= rx_data_q[1:0];
                        st_q   <= prog_entry_pkg::ST_READY;
                    end else if (cnt_q >= INIT_WINDOW_CYC)
                        st_q <= prog_entry_pkg::ST_TIMEOUT;
                end
                prog_entry_pkg::ST_READY:   st_q <= st_q;
                prog_entry_pkg::ST_TIMEOUT: st_q <= st_q;
                default: st_q <= prog_entry_pkg::ST_NORMAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // uart receiver, 8N1
    // ------------------------------------------------------------
    // [RULE10] [RULE12] line select
    assign ser_rx = two_wire_sel_i ? prog_uart_rx_pin_i : mode_serial_pin_i;

    prog_entry_pkg::rx_state_e rx_st_q;
    logic [15:0]               rx_cnt_q;
    logic [2:0]                rx_bit_q;
    logic [7:0]                rx_sh_q;
    logic                      rx_en;
    logic [15:0]               bit_len;

    // bit time at the current rate, shared by receiver and halving
    assign bit_len = bit_cyc(baud_q);

    // receiver listens only once the pin went high in programming mode
    assign rx_en = prog_q && (st_q == prog_entry_pkg::ST_WAIT_BAUD ||
                              st_q == prog_entry_pkg::ST_READY);

    // [RULE10] receive at selected rate
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_q    <= prog_entry_pkg::RX_IDLE;
            rx_cnt_q   <= 16'h0000;
            rx_bit_q   <= 3'h0;
            rx_sh_q    <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_data_q  <= 8'h00;
        end else begin
            rx_valid_q <= 1'b0;
            case (rx_st_q)
                prog_entry_pkg::RX_IDLE: begin
                    if (rx_en && !ser_rx) begin
                        rx_cnt_q <= {1'b0, bit_len[15:1]};
                        rx_st_q  <= prog_entry_pkg::RX_START;
                    end
                end
                prog_entry_pkg::RX_START: begin
                    if (rx_cnt_q == 16'h0000) begin
                        // reload one short: the zero cycle is part of the bit
                        rx_cnt_q <= bit_len - 16'h0001;
                        rx_bit_q <= 3'h0;
                        rx_st_q  <= ser_rx ? prog_entry_pkg::RX_IDLE
                                           : prog_entry_pkg::RX_DATA;
                    end else
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                end
                prog_entry_pkg::RX_DATA: begin
                    if (rx_cnt_q == 16'h0000) begin
                        rx_sh_q  <= {ser_rx, rx_sh_q[7:1]};
                        rx_cnt_q <= bit_len - 16'h0001;
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7)
                            rx_st_q <= prog_entry_pkg::RX_STOP;
                    end else
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                end
                prog_entry_pkg::RX_STOP: begin
                    if (rx_cnt_q == 16'h0000) begin
                        rx_valid_q <= ser_rx;  // framing error drops byte
                        rx_data_q  <= rx_sh_q;
                        rx_st_q    <= prog_entry_pkg::RX_IDLE;
                    end else
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                end
                default: rx_st_q <= prog_entry_pkg::RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // uart transmitter, 8N1, after entry only
    // ------------------------------------------------------------
    logic [9:0]  tx_sh_q;
    logic [3:0]  tx_left_q;
    logic [15:0] tx_cnt_q;

    // [RULE10] transmit at selected rate
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_sh_q   <= 10'h3ff;
            tx_left_q <= 4'h0;
            tx_cnt_q  <= 16'h0000;
        end else if (tx_left_q == 4'h0) begin
            if (tx_start_i && st_q == prog_entry_pkg::ST_READY) begin
                tx_sh_q   <= {1'b1, tx_data_i, 1'b0};
                tx_left_q <= 4'ha;
                tx_cnt_q  <= bit_cyc(baud_q);
            end
        end else if (tx_cnt_q == 16'h0001) begin
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_left_q <= tx_left_q - 4'h1;
            tx_cnt_q  <= bit_cyc(baud_q);
        end else
            tx_cnt_q <= tx_cnt_q - 16'h0001;
    end

    // single wire: drive low only, pull-up gives the high level
    // [RULE10] [RULE12] pin drive
    assign mode_serial_pin_o    = 1'b0;
    assign mode_serial_pin_oe_o = !two_wire_sel_i && !tx_sh_q[0];
    assign prog_uart_tx_pin_o   = two_wire_sel_i ? tx_sh_q[0] : 1'b1;
    assign tx_busy_o            = tx_left_q != 4'h0;

    // [RULE9] no restriction per mode
    assign write_erase_verify_en_o = st_q == prog_entry_pkg::ST_READY;
    assign prog_mode_o     = prog_q;
    assign entry_done_o    = st_q == prog_entry_pkg::ST_READY;
    assign entry_timeout_o = st_q == prog_entry_pkg::ST_TIMEOUT;
    assign full_speed_o    = full_speed_q;
    assign baud_code_o     = baud_q;
    assign rx_valid_o      = rx_valid_q;
    assign rx_data_o       = rx_data_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_mode_latch;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !rel_seen_q |=> prog_q == !$past(mode_serial_pin_i);
    endproperty
    a_mode_latch: assert property (p_mode_latch) // [RULE1]
        else $error("mode not taken from pin at release");

    property p_mode_stable;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        rel_seen_q |=> $stable(prog_q) && $stable(full_speed_q);
    endproperty
    a_mode_stable: assert property (p_mode_stable) // [RULE13]
        else $error("mode changed after release");

    property p_hs_full;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !rel_seen_q && flash_op_mode_i == `FOM_HS |=> full_speed_q;
    endproperty
    a_hs_full: assert property (p_hs_full) // [RULE7]
        else $error("hs setting did not pick full speed");

    property p_blank_low;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !rel_seen_q && flash_op_mode_i == `FOM_BLANK && supply_low_range_i
        |=> !full_speed_q;
    endproperty
    a_blank_low: assert property (p_blank_low) // [RULE8]
        else $error("blank low supply not wide voltage");

    property p_done_needs_baud;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(entry_done_o) |-> $past(rx_valid_q) && prog_q;
    endproperty
    a_done_needs_baud: assert property (p_done_needs_baud) // [RULE4]
        else $error("entry done without baud byte");

    property p_no_done_normal;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        rel_seen_q && !prog_q |-> st_q == prog_entry_pkg::ST_NORMAL;
    endproperty
    a_no_done_normal: assert property (p_no_done_normal) // [RULE6]
        else $error("entry sequence ran in normal mode");

    property p_tx_idle_high;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !tx_busy_o |-> prog_uart_tx_pin_o && !mode_serial_pin_oe_o;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) // [RULE10]
        else $error("line not idle while transmitter idle");

    property p_wev;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        entry_done_o |-> write_erase_verify_en_o;
    endproperty
    a_wev: assert property (p_wev) // [RULE9]
        else $error("operations blocked after entry");

    c_prog: cover property (@(posedge sys_clk_i) $rose(entry_done_o));
    c_tmo:  cover property (@(posedge sys_clk_i) $rose(entry_timeout_o));
    c_full: cover property (@(posedge sys_clk_i)
                            entry_done_o && full_speed_o);

endmodule : flash_program_mode_entry

/* verification/prog_host.sv */
`timescale 1ns/100ps
`include "prog_entry_cfg.svh"

// ----------------------------------------
// host programmer: mode port and uart
// ----------------------------------------
module prog_host #(
    parameter int unsigned BIT_CYC = `BIT_CYC_115K
) (
    input  wire logic sys_clk_i,
    input  wire logic link_rx_i,
    output logic      pin_low_o,
    output logic      uart_tx_o
);
    // idle: pin left to its pull-up, uart line high
    initial begin
        pin_low_o = 1'b0;
        uart_tx_o = 1'b1;
    end

    // mode pin drive
    // called before release and again after the low hold
    task automatic set_low(input logic low);
        @(posedge sys_clk_i);
        pin_low_o <= low;
    endtask : set_low

    // exact bit time
    // single wire pulls the mode pin, two wire drives device rx
    task automatic send(input logic [7:0] b, input logic one_wire);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_i);
            if (one_wire)
                pin_low_o <= ~f[i];
            else
                uart_tx_o <= f[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk_i);
        end
    endtask : send

    task automatic recv(input int unsigned bc, output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        while (link_rx_i !== 1'b0 && n < 50000) begin
            @(posedge sys_clk_i);
            n++;
        end
        repeat (bc / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bc) @(posedge sys_clk_i);
            b[i] = link_rx_i;
        end
    endtask : recv
endmodule : prog_host

/* verification/flash_program_mode_entry_tb_top.sv */
`timescale 1ns/100ps
`include "prog_entry_cfg.svh"

module flash_program_mode_entry_tb_top;
    // short window keeps the timeout case affordable
    localparam int unsigned WIN  = 30000;
    localparam int unsigned HOLD = 4;

    logic       sys_clk  = 1'b0;
    logic       resetn   = 1'b0;
    logic       int_done = 1'b0;
    logic       two_wire = 1'b0;
    logic       sup_low  = 1'b0;
    logic       tx_start = 1'b0;
    logic [7:0] tx_data  = 8'h00;
    logic [1:0] fom      = `FOM_HS;
    logic       pin_o, pin_oe, tx_pin, tx_busy, prog_mode, done, tmo;
    logic       full_speed, wev, rx_valid;
    logic [1:0] baud;
    logic [7:0] rx_data, got;
    wire        host_low, host_tx, pin_lvl, link_rx;
    int         fail_count = 0;
    int         checked    = 0;
    int         cyc        = 0;

    // open-drain pin with pull-up; host reads whichever link is live
    assign pin_lvl = ~(host_low | (pin_oe & ~pin_o));
    assign link_rx = two_wire ? tx_pin : pin_lvl;

    always #5 sys_clk = ~sys_clk;

    flash_program_mode_entry #(
        .INIT_WINDOW_CYC(WIN),
        .HOLD_LOW_CYC   (HOLD)
    ) u_dut (
        .sys_clk_i              (sys_clk),
        .resetn_i               (resetn),
        .internal_resets_done_i (int_done),
        .mode_serial_pin_i      (pin_lvl),
        .mode_serial_pin_o      (pin_o),
        .mode_serial_pin_oe_o   (pin_oe),
        .prog_uart_rx_pin_i     (host_tx),
        .prog_uart_tx_pin_o     (tx_pin),
        .two_wire_sel_i         (two_wire),
        .flash_op_mode_i        (fom),
        .supply_low_range_i     (sup_low),
        .tx_start_i             (tx_start),
        .tx_data_i              (tx_data),
        .tx_busy_o              (tx_busy),
        .prog_mode_o            (prog_mode),
        .entry_done_o           (done),
        .entry_timeout_o        (tmo),
        .full_speed_o           (full_speed),
        .write_erase_verify_en_o(wev),
        .baud_code_o            (baud),
        .rx_valid_o             (rx_valid),
        .rx_data_o              (rx_data)
    );

    prog_host #(
        .BIT_CYC(`BIT_CYC_115K)
    ) u_host (
        .sys_clk_i(sys_clk),
        .link_rx_i(link_rx),
        .pin_low_o(host_low),
        .uart_tx_o(host_tx)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // resets finish internally before the external release
    task automatic start(input logic low, input logic tw,
                         input logic [1:0] fm, input logic sl);
        @(posedge sys_clk);
        resetn   <= 1'b0;
        int_done <= 1'b1;
        two_wire <= tw;
        fom      <= fm;
        sup_low  <= sl;
        u_host.set_low(low);
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : start

    // hold low past the minimum, then let the pin rise
    task automatic enter();
        repeat (HOLD + 2) @(posedge sys_clk);
        u_host.set_low(1'b0);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : enter

    task automatic wait_rx(input logic [7:0] exp);
        int n;
        n = 0;
        // look just after the edge so the one-cycle pulse is settled
        while (rx_valid !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(8'(rx_valid), 8'h01);
        check(rx_data, exp);
    endtask : wait_rx

    task automatic dev_send(input logic [7:0] b);
        @(posedge sys_clk);
        tx_data  <= b;
        tx_start <= 1'b1;
        @(posedge sys_clk);
        tx_start <= 1'b0;
    endtask : dev_send

    // cycle ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        start(1'b0, 1'b0, `FOM_HS, 1'b0);
        check(8'(prog_mode), 8'h00);
        for (int i = 0; i < 8; i++) begin
            start(1'b1, 1'b0, i[1:0], i[2]);
            check(8'(prog_mode), 8'h01);
            check(8'(full_speed), 8'((i[1:0] == `FOM_HS) ||
                  (i[1:0] == `FOM_BLANK && !i[2])));
        end
        // single wire entry, then 1 Mbps reply
        start(1'b1, 1'b0, `FOM_LS, 1'b0);
        enter();
        check(8'(done), 8'h00);
        fork
            u_host.send(8'ha3, 1'b1);
            wait_rx(8'ha3);
        join
        #1;
        check(8'(done), 8'h01);
        check(8'(wev), 8'h01);
        check(8'(baud), 8'h03);
        check(8'(prog_mode), 8'h01);
        check(8'(tmo), 8'h00);
        fork
            dev_send(8'hc6);
            u_host.recv(`BIT_CYC_1M, got);
        join
        check(got, 8'hc6);
        check(8'(tx_busy), 8'h01);
        // two wire: plain byte ignored, then setting
        start(1'b1, 1'b1, `FOM_LV, 1'b1);
        enter();
        fork
            u_host.send(8'h55, 1'b0);
            wait_rx(8'h55);
        join
        check(8'(done), 8'h00);
        fork
            u_host.send(8'ha1, 1'b0);
            wait_rx(8'ha1);
        join
        #1;
        check(8'(done), 8'h01);
        check(8'(baud), 8'h01);
        fork
            dev_send(8'h5a);
            u_host.recv(`BIT_CYC_250K, got);
        join
        check(got, 8'h5a);
        // no setting byte inside the window
        start(1'b1, 1'b0, `FOM_HS, 1'b0);
        enter();
        repeat (WIN + 50) @(posedge sys_clk);
        #1;
        check(8'(tmo), 8'h01);
        check(8'(done), 8'h00);
        // transmit request refused while entry is not complete
        dev_send(8'h33);
        #1;
        check(8'(tx_busy), 8'h00);
        give_verdict();
    end
endmodule : flash_program_mode_entry_tb_top
